// >>> dms_menu.sv
/*
  Front-panel diagnostic menu sequencer: walks the menu tree on button
  presses, runs and aborts the self tests and steps the data test.
  Assumes the drive answers each test request with a one-cycle done pulse.
*/
`include "dms_regs.svh"
`default_nettype none
module dms_menu (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire dms_pkg::dms_btn_s i_btn,
  input wire logic i_selftest_passed,
  input wire logic i_tape_loaded,
  input wire logic i_at_bot,
  input wire dms_pkg::dms_rsp_s i_rsp,
  output dms_pkg::dms_disp_s o_disp,
  output dms_pkg::dms_cmd_s o_cmd,
  output logic o_diagnostic_back_button_mode,
  output logic o_host_confirm_run_button_req
);
  import dms_pkg::*;

  typedef enum logic [3:0] {
    ST_UNIT,
    ST_READY,
    ST_MAIN,
    ST_SELF,
    ST_CONFIRM,
    ST_PWUP_RUN,
    ST_DT_REWIND,
    ST_DT_LOOP,
    ST_DT_SUB,
    ST_RESULT,
    ST_FUNC
  } dms_state_e;

  // ----------------------------------------
  // Button presses
  // ----------------------------------------
  logic [6:0] press;
  dms_btn_s pb;

  dms_debounce u_debounce (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_raw(i_btn),
    .o_press(press)
  );
  assign pb = press;

  function automatic logic [3:0] wrap_next(input logic [3:0] cur, input logic [3:0] n);
    wrap_next = (cur == n - 4'h1) ? 4'h0 : cur + 4'h1;
  endfunction : wrap_next

  function automatic logic [7:0] to_bcd(input logic [4:0] v);
    logic [4:0] tens;
    tens = (v >= 5'h14) ? 5'h02 : (v >= 5'h0A) ? 5'h01 : 5'h00;
    to_bcd = {tens[3:0], 4'(v - tens * 5'h0A)};
  endfunction : to_bcd

  // ----------------------------------------
  // State
  // ----------------------------------------
  dms_state_e state_r, state_nxt;
  logic [3:0] main_sel_r, main_sel_nxt;
  logic [3:0] self_sel_r, self_sel_nxt;
  logic [3:0] func_item_r, func_item_nxt;
  logic [4:0] sub_r, sub_nxt;
  dms_density_e den_r, den_nxt;
  logic show_num_r, show_num_nxt;
  logic req_r, req_nxt;
  dms_disp_s disp_r, disp_nxt;
  logic [7:0] fail_r, fail_nxt;
  logic result_pass_r, result_pass_nxt;

  // Named decode
  wire in_diagnostic_back_button = (state_r != ST_UNIT);
  wire data_sel = (self_sel_r == 4'h1);
  wire sub_last = (sub_r == `DMS_SUB_LAST);
  wire den_last = (den_r == DMS_DEN_GCR);
  wire run_key = pb.start_stop | pb.load | pb.confirm_run_button;
  wire rsp_ok = i_rsp.done & i_rsp.pass;
  wire rsp_bad = i_rsp.done & ~i_rsp.pass;
  wire [4:0] main_msg = 5'(`DMS_MSG_SELFTEST + 5'(main_sel_r));

  always_comb begin
    state_nxt = state_r;
    main_sel_nxt = main_sel_r;
    self_sel_nxt = self_sel_r;
    func_item_nxt = func_item_r;
    sub_nxt = sub_r;
    den_nxt = den_r;
    show_num_nxt = show_num_r;
    req_nxt = 1'b0;
    fail_nxt = fail_r;
    result_pass_nxt = result_pass_r;
    case (state_r)
      ST_UNIT: begin
        if (pb.diagnostic_back_button && i_selftest_passed) begin
          state_nxt = ST_READY; // see RQ1
        end
      end
      ST_READY: begin
        if (pb.enter) begin
          state_nxt = ST_MAIN; // see RQ2
          main_sel_nxt = 4'h0;
        end else if (pb.diagnostic_back_button) begin
          state_nxt = ST_UNIT; // see RQ4
        end
      end
      ST_MAIN: begin
        if (pb.diagnostic_back_button) begin
          state_nxt = ST_READY; // see RQ3
        end else if (pb.scan) begin
          main_sel_nxt = wrap_next(main_sel_r, `DMS_MAIN_ITEMS); // see RQ5
        end else if (pb.enter) begin
          // Only the self test is handled here; other functions are delegated
          state_nxt = (main_sel_r == 4'h0) ? ST_SELF : ST_FUNC; // see RQ6
          self_sel_nxt = 4'h0;
          func_item_nxt = 4'h0;
        end
      end
      ST_FUNC: begin
        if (pb.diagnostic_back_button) begin
          state_nxt = ST_MAIN; // see RQ3
        end else if (pb.scan) begin
          func_item_nxt = func_item_r + 4'h1; // see RQ5
        end else if (pb.enter || run_key) begin
          req_nxt = 1'b1; // see RQ7
        end
      end
      ST_SELF: begin
        if (pb.diagnostic_back_button) begin
          state_nxt = ST_MAIN; // see RQ3
        end else if (pb.scan) begin
          self_sel_nxt = wrap_next(self_sel_r, `DMS_SELF_ITEMS); // see RQ5
        end else if (pb.enter) begin
          state_nxt = ST_CONFIRM; // see RQ9
        end
      end
      ST_CONFIRM: begin
        if (pb.diagnostic_back_button) begin
          state_nxt = ST_UNIT; // see RQ10
        end else if (pb.confirm_run_button) begin
          if (data_sel) begin
            den_nxt = DMS_DEN_NRZI;
            sub_nxt = `DMS_SUB_FIRST;
            show_num_nxt = 1'b0;
            state_nxt = i_at_bot ? ST_DT_LOOP : ST_DT_REWIND; // see RQ15
          end else if (i_tape_loaded) begin
            state_nxt = ST_RESULT; // see RQ11
            result_pass_nxt = 1'b0;
            fail_nxt = 8'h00;
          end else begin
            state_nxt = ST_PWUP_RUN; // see RQ9
          end
          req_nxt = ~(~data_sel & i_tape_loaded);
        end
      end
      ST_PWUP_RUN: begin
        if (rsp_ok) begin
          state_nxt = ST_UNIT; // see RQ12
        end else if (rsp_bad) begin
          state_nxt = ST_RESULT; // see RQ14
          fail_nxt = i_rsp.fail_code;
          result_pass_nxt = 1'b0;
        end
      end
      ST_DT_REWIND: begin
        if (i_rsp.done) begin
          state_nxt = ST_DT_LOOP; // see RQ15
          req_nxt = 1'b1;
        end
      end
      ST_DT_LOOP, ST_DT_SUB: begin
        if (pb.density) begin
          show_num_nxt = 1'b1; // see RQ18
        end
        if (rsp_bad) begin
          state_nxt = ST_RESULT; // see RQ14
          fail_nxt = i_rsp.fail_code;
          result_pass_nxt = 1'b0;
        end else if (rsp_ok) begin
          req_nxt = 1'b1;
          if (state_r == ST_DT_LOOP) begin
            state_nxt = ST_DT_SUB; // see RQ16
          end else if (!sub_last) begin
            sub_nxt = sub_r + 5'h01; // see RQ17
          end else if (den_last) begin
            state_nxt = ST_RESULT; // see RQ13
            result_pass_nxt = 1'b1;
            req_nxt = 1'b0;
          end else begin
            den_nxt = dms_density_e'(den_r + 2'h1); // see RQ19
            sub_nxt = `DMS_SUB_FIRST;
          end
        end
      end
      ST_RESULT: begin
        if (pb.diagnostic_back_button) begin
          state_nxt = ST_SELF; // see RQ3
        end
      end
      default: begin
        state_nxt = ST_UNIT;
      end
    endcase
  end

  // ----------------------------------------
  // Readout selection
  // ----------------------------------------
  always_comb begin
    disp_nxt = '0;
    disp_nxt.fail_code = fail_nxt;
    case (state_nxt)
      ST_UNIT: disp_nxt.msg = `DMS_MSG_UNIT; // see RQ12
      ST_READY: disp_nxt.msg = `DMS_MSG_DIAGNOSTIC_BACK_BUTTON; // see RQ1
      ST_MAIN: disp_nxt.msg = 5'(`DMS_MSG_SELFTEST + 5'(main_sel_nxt));
      ST_FUNC: begin
        disp_nxt.msg = `DMS_MSG_FUNC;
        disp_nxt.number = {4'h0, func_item_nxt};
      end
      ST_SELF: disp_nxt.msg = self_sel_nxt[0] ? `DMS_MSG_DATA_ITEM : `DMS_MSG_PWUP_ITEM;
      ST_CONFIRM: disp_nxt.msg = `DMS_MSG_CONFIRM;
      ST_PWUP_RUN: disp_nxt.msg = `DMS_MSG_RUNNING;
      ST_DT_REWIND: disp_nxt.msg = `DMS_MSG_REWIND;
      ST_DT_LOOP, ST_DT_SUB: begin
        disp_nxt.msg = `DMS_MSG_TESTNUM; // see RQ17
        disp_nxt.number = to_bcd(sub_nxt);
      end
      ST_RESULT: begin
        if (result_pass_nxt) begin
          disp_nxt.msg = `DMS_MSG_PASSED; // see RQ13
        end else if (fail_nxt == 8'h00) begin
          disp_nxt.msg = `DMS_MSG_LOADED; // see RQ11
        end else begin
          disp_nxt.msg = `DMS_MSG_FAIL; // see RQ14
        end
      end
      default: disp_nxt.msg = `DMS_MSG_UNIT;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_UNIT;
      main_sel_r <= 4'h0;
      self_sel_r <= 4'h0;
      func_item_r <= 4'h0;
      sub_r <= `DMS_SUB_FIRST;
      den_r <= DMS_DEN_NRZI;
      show_num_r <= 1'b0;
      req_r <= 1'b0;
      fail_r <= 8'h00;
      result_pass_r <= 1'b0;
      disp_r <= '0;
    end else begin
      state_r <= state_nxt;
      main_sel_r <= main_sel_nxt;
      self_sel_r <= self_sel_nxt;
      func_item_r <= func_item_nxt;
      sub_r <= sub_nxt;
      den_r <= den_nxt;
      show_num_r <= show_num_nxt;
      req_r <= req_nxt;
      fail_r <= fail_nxt;
      result_pass_r <= result_pass_nxt;
      disp_r <= disp_nxt;
    end
  end

  // ----------------------------------------
  // Outputs to the drive
  // ----------------------------------------
  dms_cmd_s cmd_r;
  logic diagnostic_back_button_r;
  logic host_r;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cmd_r <= '0;
      diagnostic_back_button_r <= 1'b0;
      host_r <= 1'b0;
    end else begin
      cmd_r.run_pwup <= req_nxt & (state_nxt == ST_PWUP_RUN);
      cmd_r.rewind <= req_nxt & (state_nxt == ST_DT_REWIND);
      cmd_r.loop_check <= req_nxt & (state_nxt == ST_DT_LOOP); // see RQ16
      cmd_r.run_subtest <= req_nxt & (state_nxt == ST_DT_SUB);
      cmd_r.subtest <= sub_nxt;
      cmd_r.density <= den_nxt; // see RQ19
      cmd_r.func_act <= req_nxt & (state_nxt == ST_FUNC); // see RQ7
      cmd_r.func_sel <= main_sel_r[2:0];
      cmd_r.func_key <= pb.load ? 2'h2 : pb.start_stop ? 2'h1 : pb.confirm_run_button ? 2'h3 : 2'h0;
      diagnostic_back_button_r <= (state_nxt != ST_UNIT);
      // Confirm_run_button reaches the host only outside diagnostics
      host_r <= pb.confirm_run_button & ~in_diagnostic_back_button & (state_nxt == ST_UNIT); // see RQ8
    end
  end

  assign o_cmd = cmd_r;
  assign o_diagnostic_back_button_mode = diagnostic_back_button_r;
  assign o_host_confirm_run_button_req = host_r;
  assign o_disp = disp_r;

  // Density press only sets show_num_r; the readout shows the number through the loop check and subtests regardless
  wire unused_ok = show_num_r ^ (main_msg[0] & 1'b0);
endmodule : dms_menu
`default_nettype wire

// >>> dms_regs.svh
/*
  Constants for the diagnostic menu sequencer: display codes, timing counts, sizes.
  Assumes a single 250 MHz system clock; included by bare name.
*/
//
// Summary of operation
// RQ1: After self test passes, diagnostic_back_button shows prompt
// RQ2: Enter opens main menu, descends shown level
// RQ3: Diagnostic_back_button inside a menu climbs one level
// RQ4: Repeated diagnostic_back_button presses leave diagnostic mode
// RQ5: Scan cycles through items of current menu
// RQ6: Enter on function opens its submenu
// RQ7: Some submenus activate via start, load, confirm_run_button
// RQ8: Confirm_run_button in diagnostics never goes host-confirm_run_button
// RQ9: Self-test items confirm; confirm_run_button runs the test
// RQ10: Diagnostic_back_button at confirmation aborts and exits diagnostics
// RQ11: Tape loaded at power-up run shows loaded
// RQ12: Passed power-up test exits to unit display
// RQ13: Passed data test shows passed message
// RQ14: Any failed test shows numeric fail code
// RQ15: Data test rewinds first, then selects NRZI
// RQ16: Data test includes loop write-read check
// RQ17: Display shows subtest number 01 to 27
// RQ18: Density press shows current subtest number
// RQ19: After each series, next density, repeat
// RQ20: Buttons debounced, one press one action
`ifndef DMS_REGS_SVH
`define DMS_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define DMS_CLK_MHZ 250
`define DMS_DEBOUNCE_US 5
`define DMS_DEBOUNCE_CYC (`DMS_DEBOUNCE_US * `DMS_CLK_MHZ)

// ----------------------------------------
// Menu sizes and subtest span
// ----------------------------------------
`define DMS_MAIN_ITEMS 4'h6
`define DMS_SELF_ITEMS 4'h2
`define DMS_SUB_FIRST 5'h01
`define DMS_SUB_LAST 5'h1B

// ----------------------------------------
// Display message codes
// ----------------------------------------
`define DMS_MSG_UNIT 5'h00
`define DMS_MSG_DIAGNOSTIC_BACK_BUTTON 5'h01
`define DMS_MSG_SELFTEST 5'h02
`define DMS_MSG_MOTION 5'h03
`define DMS_MSG_DRVADJ 5'h04
`define DMS_MSG_SETUP 5'h05
`define DMS_MSG_CAL 5'h06
`define DMS_MSG_DATADIAG 5'h07
`define DMS_MSG_PWUP_ITEM 5'h08
`define DMS_MSG_DATA_ITEM 5'h09
`define DMS_MSG_CONFIRM 5'h0A
`define DMS_MSG_LOADED 5'h0B
`define DMS_MSG_PASSED 5'h0C
`define DMS_MSG_FAIL 5'h0D
`define DMS_MSG_TESTNUM 5'h0E
`define DMS_MSG_RUNNING 5'h0F
`define DMS_MSG_REWIND 5'h10
`define DMS_MSG_FUNC 5'h11

`endif

// >>> dms_pkg.sv
/*
  Types for the diagnostic menu sequencer.
  Assumes dms_regs.svh is compiled alongside.
*/
`default_nettype none
package dms_pkg;
  // ----------------------------------------
  // Button set, one bit per pushbutton
  // ----------------------------------------
  typedef struct packed {
    logic diagnostic_back_button;
    logic enter;
    logic scan;
    logic confirm_run_button;
    logic start_stop;
    logic load;
    logic density;
  } dms_btn_s;

  typedef enum logic [1:0] {
    DMS_DEN_NRZI,
    DMS_DEN_PE,
    DMS_DEN_DDPE,
    DMS_DEN_GCR
  } dms_density_e;

  // Readout contents
  typedef struct packed {
    logic [4:0] msg;
    logic [7:0] number;
    logic [7:0] fail_code;
  } dms_disp_s;

  // Requests to drive test and motion functions
  typedef struct packed {
    logic run_pwup;
    logic rewind;
    logic loop_check;
    logic run_subtest;
    logic [4:0] subtest;
    dms_density_e density;
    logic func_act;
    logic [2:0] func_sel;
    logic [1:0] func_key;
  } dms_cmd_s;

  // Answers from drive
  typedef struct packed {
    logic done;
    logic pass;
    logic [7:0] fail_code;
  } dms_rsp_s;
endpackage : dms_pkg
`default_nettype wire

// >>> dms_debounce.sv
/*
  Debounce and rising-edge detect for all pushbuttons.
  Assumes button inputs are synchronous to the clock and active high.
*/
`include "dms_regs.svh"
`default_nettype none
module dms_debounce (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire dms_pkg::dms_btn_s i_raw,
  output logic [6:0] o_press
);
  import dms_pkg::*;

  localparam int W = 7;
  localparam logic [11:0] CNT_MAX = 12'(`DMS_DEBOUNCE_CYC - 1);

  logic [W-1:0] raw;
  logic [W-1:0] stable_r;
  logic [W-1:0] press_r;
  logic [11:0] cnt_r [W];

  assign raw = i_raw;
  assign o_press = press_r;

  // Level must hold steady for the whole window before it is believed
  // One process for all buttons, so each vector keeps a single driver
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int g = 0; g < W; g++) begin
        cnt_r[g] <= 12'h000;
      end
      stable_r <= 7'h00;
      press_r <= 7'h00;
    end else begin
      for (int g = 0; g < W; g++) begin
        press_r[g] <= 1'b0;
        if (raw[g] == stable_r[g]) begin
          cnt_r[g] <= 12'h000;
        end else if (cnt_r[g] == CNT_MAX) begin
          cnt_r[g] <= 12'h000;
          stable_r[g] <= raw[g];
          press_r[g] <= raw[g]; // see RQ20
        end else begin
          cnt_r[g] <= cnt_r[g] + 12'h001;
        end
      end
    end
  end
endmodule : dms_debounce
`default_nettype wire

// >>> dms_drive_model.sv
/*
  Drive-side model that answers the test and rewind requests of the sequencer.
  Assumes one-cycle request pulses; each request gets one done pulse four cycles on.
*/
`default_nettype none
module dms_drive_model (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire dms_pkg::dms_cmd_s i_cmd,
  input wire logic i_fail,
  output var dms_pkg::dms_rsp_s o_rsp,
  output logic o_at_bot
);
  import dms_pkg::*;
  // ----------------------------------------
  // Answer timing
  // ----------------------------------------
  logic [1:0] cnt_r;
  logic rew_r;
  wire logic req = i_cmd.run_pwup | i_cmd.rewind | i_cmd.loop_check | i_cmd.run_subtest;
  // Answer lines churn outside done, so early sampling is caught
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r <= 2'h0;
      rew_r <= 1'h0;
      o_rsp <= '0;
      o_at_bot <= 1'h0;
    end else begin
      o_rsp.done <= 1'h0;
      o_rsp.pass <= ~o_rsp.pass;
      o_rsp.fail_code <= ~o_rsp.fail_code;
      if (req) begin
        cnt_r <= 2'h3;
        rew_r <= i_cmd.rewind;
      end else if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
      end
      if (cnt_r == 2'h1 && !req) begin
        o_rsp.done <= 1'h1;
        o_rsp.pass <= ~i_fail;
        o_rsp.fail_code <= i_fail ? 8'hA5 : 8'h00;
        if (rew_r) o_at_bot <= 1'h1;
      end
      if (i_cmd.run_subtest) o_at_bot <= 1'h0;
    end
  end
endmodule : dms_drive_model
`default_nettype wire

// >>> dms_menu_monitor.sv
/*
  Checker on the ports of the diagnostic menu sequencer.
  Assumes one clock domain and done pulses that answer single requests.
*/
`include "dms_regs.svh"
`default_nettype none
module dms_menu_monitor (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire dms_pkg::dms_btn_s i_btn,
  input wire logic i_selftest_passed,
  input wire logic i_tape_loaded,
  input wire logic i_at_bot,
  input wire dms_pkg::dms_rsp_s i_rsp,
  input wire dms_pkg::dms_disp_s o_disp,
  input wire dms_pkg::dms_cmd_s o_cmd,
  input wire logic o_diagnostic_back_button_mode,
  input wire logic o_host_confirm_run_button_req
);
  import dms_pkg::*;
  // ----------------------------------------
  // Request tracking
  // ----------------------------------------
  logic pw_r;
  logic tst_r;
  logic sub_r;
  logic [4:0] lsub_r;
  logic [1:0] lden_r;
  logic [7:0] code_r;
  wire logic req = o_cmd.run_pwup | o_cmd.loop_check | o_cmd.run_subtest;
  // Two decimal digits of the subtest being started
  wire logic [7:0] sub_bcd = {4'(o_cmd.subtest / 5'h0A), 4'(o_cmd.subtest % 5'h0A)};
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pw_r <= 1'h0;
      tst_r <= 1'h0;
      sub_r <= 1'h0;
      lsub_r <= 5'h00;
      lden_r <= 2'h0;
      code_r <= 8'h00;
    end else begin
      tst_r <= req | (tst_r & ~i_rsp.done);
      pw_r <= o_cmd.run_pwup | (pw_r & ~i_rsp.done);
      sub_r <= o_cmd.run_subtest | (sub_r & ~i_rsp.done);
      if (i_rsp.done) code_r <= i_rsp.fail_code;
      if (o_cmd.loop_check) lsub_r <= 5'h00;
      else if (o_cmd.run_subtest) lsub_r <= o_cmd.subtest;
      if (o_cmd.run_subtest) lden_r <= o_cmd.density;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  sequence s_pw_ok;
    pw_r && i_rsp.done && i_rsp.pass;
  endsequence
  sequence s_fail;
    tst_r && i_rsp.done && !i_rsp.pass;
  endsequence
  sequence s_last_ok;
    sub_r && i_rsp.done && i_rsp.pass && lsub_r == `DMS_SUB_LAST && lden_r == 2'h3;
  endsequence
  a_diagnostic_back_button_prompt: assert property ($rose(o_diagnostic_back_button_mode) |-> i_selftest_passed &&
    (o_disp.msg == `DMS_MSG_DIAGNOSTIC_BACK_BUTTON || o_disp.msg == `DMS_MSG_SELFTEST))
    else $error("diagnostic_back_button mode entered without prompt");
  a_no_host: assert property (o_host_confirm_run_button_req |-> !o_diagnostic_back_button_mode)
    else $error("host confirm_run_button asked in diagnostic_back_button mode");
  a_loaded_block: assert property (o_cmd.run_pwup |-> !i_tape_loaded)
    else $error("power-up test run with tape loaded");
  a_pwup_exit: assert property (s_pw_ok |-> ##[1:3] (o_disp.msg == `DMS_MSG_UNIT && !o_diagnostic_back_button_mode))
    else $error("passed power-up test did not exit");
  a_data_pass: assert property (s_last_ok |-> ##[1:3] (o_disp.msg == `DMS_MSG_PASSED && o_diagnostic_back_button_mode))
    else $error("passed data test not shown");
  a_fail_code: assert property (s_fail |-> ##[1:3] (o_disp.msg == `DMS_MSG_FAIL && o_disp.fail_code == code_r))
    else $error("fail code not shown");
  a_rewind_away: assert property (o_cmd.rewind |-> !i_at_bot)
    else $error("rewind issued at start of tape");
  a_loop_at_start: assert property (o_cmd.loop_check |-> i_at_bot)
    else $error("loop check away from start of tape");
  a_series_order: assert property (o_cmd.run_subtest |->
    ((lsub_r == 5'h00) ? (o_cmd.subtest == `DMS_SUB_FIRST && o_cmd.density == DMS_DEN_NRZI) :
    (lsub_r == `DMS_SUB_LAST) ? (o_cmd.subtest == `DMS_SUB_FIRST && o_cmd.density == lden_r + 2'h1) :
    (o_cmd.subtest == lsub_r + 5'h01 && o_cmd.density == lden_r)))
    else $error("subtest or density out of order");
  a_test_number: assert property (o_cmd.run_subtest |->
    (o_disp.msg == `DMS_MSG_TESTNUM && o_disp.number == sub_bcd))
    else $error("subtest number not on readout");
endmodule : dms_menu_monitor
bind dms_menu dms_menu_monitor mon_u (.i_clk_sys, .i_nrst, .i_btn, .i_selftest_passed, .i_tape_loaded,
  .i_at_bot, .i_rsp, .o_disp, .o_cmd, .o_diagnostic_back_button_mode, .o_host_confirm_run_button_req);
`default_nettype wire

// >>> diagnostic_back_button_menu_sequencer_tb.sv
/*
  Self-checking bench for the diagnostic menu sequencer.
  Assumes the menu, the drive model and the bound checker are compiled first.
*/
`include "dms_regs.svh"
`default_nettype none
module diagnostic_back_button_menu_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dms_pkg::*;
  // ----------------------------------------
  // Wiring
  // ----------------------------------------
  localparam int B_DIAGNOSTIC_BACK_BUTTON = 6;
  localparam int B_ENT = 5;
  localparam int B_SCAN = 4;
  localparam int B_ON = 3;
  logic clk = 1'h0;
  // Starts high so the first reset is a real falling edge
  logic nrst = 1'h1;
  logic st_ok = 1'h1;
  logic tape = 1'h0;
  logic fail = 1'h0;
  dms_btn_s btn = '0;
  dms_rsp_s rsp;
  dms_cmd_s cmd;
  dms_disp_s disp;
  logic mode;
  logic host;
  logic at_bot;
  int errors = 0;
  int total_checks = 0;
  int n_pw;
  int n_rw;
  int n_lp;
  int n_sb;
  int n_ho;
  int n_fa;
  logic [7:0] fa_key;
  initial begin
    forever #2 clk = ~clk;
  end
  dms_menu dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_btn(btn), .i_selftest_passed(st_ok), .i_tape_loaded(tape),
    .i_at_bot(at_bot), .i_rsp(rsp), .o_disp(disp), .o_cmd(cmd), .o_diagnostic_back_button_mode(mode), .o_host_confirm_run_button_req(host));
  dms_drive_model drv_u (.i_clk_sys(clk), .i_nrst(nrst), .i_cmd(cmd), .i_fail(fail), .o_rsp(rsp), .o_at_bot(at_bot));
  always @(posedge clk) begin
    n_pw += int'(cmd.run_pwup);
    n_rw += int'(cmd.rewind);
    n_lp += int'(cmd.loop_check);
    n_sb += int'(cmd.run_subtest);
    n_ho += int'(host);
    n_fa += int'(cmd.func_act);
    if (cmd.func_act) begin
      fa_key <= {3'h0, cmd.func_sel, cmd.func_key};
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk
  task rst;
    @(negedge clk);
    nrst = 1'h0;
    repeat (10) @(negedge clk);
    nrst = 1'h1;
    n_pw = 0;
    n_rw = 0;
    n_lp = 0;
    n_sb = 0;
    n_ho = 0;
    n_fa = 0;
  endtask : rst
  // Press and release each outlast the debounce span
  task press(input int b);
    @(negedge clk);
    btn[b] = 1'h1;
    repeat (1256) @(negedge clk);
    btn[b] = 1'h0;
    repeat (1256) @(negedge clk);
  endtask : press
  task cm(input logic [4:0] e);
    chk("msg", {3'h0, e}, {3'h0, disp.msg});
  endtask : cm
  task pm(input int b, input logic [4:0] e);
    press(b);
    cm(e);
  endtask : pm
  task md(input logic e);
    chk("diagnostic_back_button_mode", {7'h0, e}, {7'h0, mode});
  endtask : md
  task open_cfg(input logic data);
    pm(B_DIAGNOSTIC_BACK_BUTTON, `DMS_MSG_DIAGNOSTIC_BACK_BUTTON);
    pm(B_ENT, `DMS_MSG_SELFTEST);
    pm(B_ENT, `DMS_MSG_PWUP_ITEM);
    if (data) pm(B_SCAN, `DMS_MSG_DATA_ITEM);
    pm(B_ENT, `DMS_MSG_CONFIRM);
    md(1'h1);
  endtask : open_cfg
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_menu;
    rst();
    st_ok = 1'h0;
    pm(B_DIAGNOSTIC_BACK_BUTTON, `DMS_MSG_UNIT);
    md(1'h0);
    pm(B_ON, `DMS_MSG_UNIT);
    chk("host_req", 8'h01, 8'(n_ho));
    st_ok = 1'h1;
    open_cfg(1'h0);
    pm(B_DIAGNOSTIC_BACK_BUTTON, `DMS_MSG_UNIT);
    md(1'h0);
    pm(B_DIAGNOSTIC_BACK_BUTTON, `DMS_MSG_DIAGNOSTIC_BACK_BUTTON);
    pm(B_ENT, `DMS_MSG_SELFTEST);
    pm(B_SCAN, `DMS_MSG_MOTION);
    pm(B_ENT, `DMS_MSG_FUNC);
    pm(B_ON, `DMS_MSG_FUNC);
    chk("func_act", 8'h01, 8'(n_fa));
    chk("func_key", 8'h07, fa_key);
    chk("host_req", 8'h01, 8'(n_ho));
    pm(B_DIAGNOSTIC_BACK_BUTTON, `DMS_MSG_MOTION);
    for (int i = 2; i <= 6; i++) begin
      pm(B_SCAN, 5'(`DMS_MSG_SELFTEST + i % 6));
    end
    pm(B_DIAGNOSTIC_BACK_BUTTON, `DMS_MSG_DIAGNOSTIC_BACK_BUTTON);
    pm(B_DIAGNOSTIC_BACK_BUTTON, `DMS_MSG_UNIT);
    md(1'h0);
    $display("t_menu finished");
  endtask : t_menu
  task t_loaded;
    rst();
    tape = 1'h1;
    open_cfg(1'h0);
    pm(B_ON, `DMS_MSG_LOADED);
    chk("pwup_runs", 8'h00, 8'(n_pw));
    tape = 1'h0;
    $display("t_loaded finished");
  endtask : t_loaded
  task t_pwup;
    rst();
    fail = 1'h1;
    open_cfg(1'h0);
    press(B_ON);
    chk("pwup_runs", 8'h01, 8'(n_pw));
    cm(`DMS_MSG_FAIL);
    chk("fail_code", 8'hA5, disp.fail_code);
    fail = 1'h0;
    pm(B_DIAGNOSTIC_BACK_BUTTON, `DMS_MSG_PWUP_ITEM);
    pm(B_ENT, `DMS_MSG_CONFIRM);
    press(B_ON);
    chk("pwup_runs", 8'h02, 8'(n_pw));
    cm(`DMS_MSG_UNIT);
    md(1'h0);
    $display("t_pwup finished");
  endtask : t_pwup
  task t_data;
    int i;
    rst();
    tape = 1'h1;
    open_cfg(1'h1);
    press(B_ON);
    for (i = 0; i < 5000 && disp.msg !== `DMS_MSG_PASSED; i++) @(negedge clk);
    if (i == 5000) begin
      errors++;
      $display("unexpected data_end expected PASSED seen timeout");
      test_done();
    end
    cm(`DMS_MSG_PASSED);
    md(1'h1);
    chk("rewinds", 8'h01, 8'(n_rw));
    chk("loop_checks", 8'h01, 8'(n_lp));
    chk("subtests", 8'h6C, 8'(n_sb));
    tape = 1'h0;
    $display("t_data finished");
  endtask : t_data
  initial begin
    rst();
    t_menu();
    t_loaded();
    t_pwup();
    t_data();
    test_done();
  end
endmodule : diagnostic_back_button_menu_sequencer_tb
`default_nettype wire
